// ==== verilog/bfsp_port.sv ====
// device-side byte-flow serial host port: paced transmitter, receiver, handshakes
`timescale 1ns/1ns
`default_nettype none
`include "bfsp_regs.svh"

module bfsp_port
    import bfsp_pkg::*;
#(
    parameter int unsigned ACK_CYC    = `BFSP_ACK_CYC,
    parameter int unsigned GAP_CYC    = `BFSP_GAP_CYC,
    parameter int          FIFO_DEPTH = `BFSP_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // configuration and network status
    input  wire logic                       byte_paced_mode,
    input  wire logic                       net_joined,
    input  wire logic                       net_buf_space,
    // serial lines and handshakes
    output logic                            uart_tx,
    input  wire logic                       uart_rx,
    output logic                            module_wake_request_n,
    input  wire logic                       host_ready_n,
    output logic                            module_accept_ready_n,
    input  wire logic                       time_strobe_n,
    // outgoing packet bytes from the device core
    input  wire logic                       tx_valid,
    input  wire logic [`BFSP_DATA_BITS-1:0] tx_data,
    input  wire logic                       tx_last,
    output logic                            tx_ready,
    // incoming bytes to the device core
    output logic                            rx_valid,
    output logic [`BFSP_DATA_BITS-1:0]      rx_data,
    output logic                            rx_frame_err,
    // timestamp packet request to the device core
    output logic                            ts_request
);

    localparam bfsp_baud_t BIT_LAST   = bfsp_baud_t'(`BFSP_BIT_CYC - 1);
    localparam bfsp_baud_t HALF_LAST  = bfsp_baud_t'(`BFSP_HALF_CYC - 1);
    localparam bfsp_bits_t FRAME_LAST = bfsp_bits_t'(`BFSP_FRAME_BITS - 1);
    localparam bfsp_bits_t DATA_LAST  = bfsp_bits_t'(`BFSP_DATA_BITS - 1);
    localparam bfsp_filt_t FILT_LAST  = bfsp_filt_t'(`BFSP_STROBE_CYC - 1);
    localparam bfsp_long_t ACK_LAST   = bfsp_long_t'(ACK_CYC - 1);
    localparam bfsp_long_t GAP_LAST   = bfsp_long_t'(GAP_CYC - 1);
    localparam int         FW         = `BFSP_DATA_BITS + 1;

    localparam bfsp_state_t S_RST = '{
        tx_st:     BFSP_TX_IDLE,
        tx_baud:   '0,
        tx_bits:   '0,
        tx_shift:  '1,
        tx_last:   1'b0,
        tx_line:   `BFSP_IDLE_LEVEL,
        seen_high: 1'b0,
        long_cnt:  '0,
        wake_n:    1'b1,
        accept_n:  1'b1,
        rx_st:     BFSP_RX_IDLE,
        rx_baud:   '0,
        rx_bits:   '0,
        rx_shift:  '0,
        rx_prev:   `BFSP_IDLE_LEVEL,
        rx_data:   '0,
        rx_valid:  1'b0,
        rx_err:    1'b0,
        filt:      '1,
        fcnt:      '0,
        ts_req:    1'b0
    };

    bfsp_state_t             s;
    bfsp_state_t             next_s;
    logic [`BFSP_IN_NUM-1:0] raw_in;
    logic                    buf_valid;
    logic [FW-1:0]           buf_data;
    logic                    buf_pop;
    logic                    ready_low;
    logic                    pace_go;

    // decouples the core from host pacing; a stalled host backs up into tx_ready
    bfsp_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_txbuf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (tx_valid),
        .in_data   ({tx_last, tx_data}),
        .in_ready  (tx_ready),
        .out_valid (buf_valid),
        .out_data  (buf_data),
        .out_ready (buf_pop)
    );

    assign raw_in[`BFSP_IN_READY] = host_ready_n;
    assign raw_in[`BFSP_IN_TIME]  = time_strobe_n;
    assign ready_low = ~s.filt[`BFSP_IN_READY];
    // packet pacing needs only ready low; byte pacing needs a fresh high-low pulse
    assign pace_go = ready_low & buf_valid & (s.seen_high | ~byte_paced_mode);

    always_comb begin
        next_s          = s;
        next_s.rx_valid = 1'b0;
        next_s.rx_err   = 1'b0;
        buf_pop         = 1'b0;

        // strobes shorter than the minimum width are rejected as glitches
        for (int i = 0; i < `BFSP_IN_NUM; i++) begin
            if (raw_in[i] != s.filt[i]) begin
                if (s.fcnt[i] == FILT_LAST) begin
                    next_s.filt[i] = raw_in[i];
                    next_s.fcnt[i] = '0;
                end else begin
                    next_s.fcnt[i] = s.fcnt[i] + 1'b1;
                end
            end else begin
                next_s.fcnt[i] = '0;
            end
        end
        // one-cycle request on each accepted falling strobe
        next_s.ts_req = s.filt[`BFSP_IN_TIME] & ~next_s.filt[`BFSP_IN_TIME];

        // not joined or no room: refuse network-bound packets
        next_s.accept_n = ~(net_joined & net_buf_space);

        // transmitter
        if (~ready_low) begin
            next_s.seen_high = 1'b1;
        end
        case (s.tx_st)
            BFSP_TX_IDLE: begin
                if (buf_valid) begin
                    next_s.wake_n   = 1'b0;
                    next_s.long_cnt = '0;
                    next_s.tx_st    = BFSP_TX_WAKE;
                end
            end
            BFSP_TX_WAKE: begin
                if (ready_low) begin
                    // release and start in the same cycle, far inside 10 ms
                    next_s.wake_n    = 1'b1;
                    next_s.tx_shift  = {1'b1, buf_data[`BFSP_DATA_BITS-1:0], 1'b0};
                    next_s.tx_last   = buf_data[`BFSP_LAST_FLAG];
                    next_s.tx_line   = 1'b0;
                    next_s.tx_baud   = '0;
                    next_s.tx_bits   = '0;
                    next_s.seen_high = 1'b0;
                    buf_pop          = 1'b1;
                    next_s.tx_st     = BFSP_TX_SEND;
                end else if (s.long_cnt == ACK_LAST) begin
                    // give up; byte stays queued and wake retries after the gap
                    next_s.wake_n   = 1'b1;
                    next_s.long_cnt = '0;
                    next_s.tx_st    = BFSP_TX_GAP;
                end else begin
                    next_s.long_cnt = s.long_cnt + 1'b1;
                end
            end
            BFSP_TX_SEND: begin
                if (s.tx_baud == BIT_LAST) begin
                    next_s.tx_baud = '0;
                    if (s.tx_bits == FRAME_LAST) begin
                        next_s.tx_line  = `BFSP_IDLE_LEVEL;
                        next_s.long_cnt = '0;
                        next_s.tx_st    = s.tx_last ? BFSP_TX_GAP : BFSP_TX_PACE;
                    end else begin
                        next_s.tx_shift = {1'b1, s.tx_shift[`BFSP_FRAME_BITS-1:1]};
                        next_s.tx_line  = s.tx_shift[1];
                        next_s.tx_bits  = s.tx_bits + 1'b1;
                    end
                end else begin
                    next_s.tx_baud = s.tx_baud + 1'b1;
                end
            end
            BFSP_TX_PACE: begin
                if (pace_go) begin
                    next_s.tx_shift  = {1'b1, buf_data[`BFSP_DATA_BITS-1:0], 1'b0};
                    next_s.tx_last   = buf_data[`BFSP_LAST_FLAG];
                    next_s.tx_line   = 1'b0;
                    next_s.tx_baud   = '0;
                    next_s.tx_bits   = '0;
                    next_s.seen_high = 1'b0;
                    buf_pop          = 1'b1;
                    next_s.tx_st     = BFSP_TX_SEND;
                end
            end
            BFSP_TX_GAP: begin
                if (s.long_cnt == GAP_LAST) begin
                    next_s.tx_st = BFSP_TX_IDLE;
                end else begin
                    next_s.long_cnt = s.long_cnt + 1'b1;
                end
            end
            default: begin
                next_s.tx_st   = BFSP_TX_IDLE;
                next_s.tx_line = `BFSP_IDLE_LEVEL;
                next_s.wake_n  = 1'b1;
            end
        endcase

        // receiver: always listening, local and network traffic alike
        next_s.rx_prev = uart_rx;
        case (s.rx_st)
            BFSP_RX_IDLE: begin
                if (s.rx_prev & ~uart_rx) begin
                    next_s.rx_baud = '0;
                    next_s.rx_st   = BFSP_RX_START;
                end
            end
            BFSP_RX_START: begin
                if (s.rx_baud == HALF_LAST) begin
                    next_s.rx_baud = '0;
                    next_s.rx_bits = '0;
                    // a start bit gone high by mid-bit was noise
                    next_s.rx_st   = uart_rx ? BFSP_RX_IDLE : BFSP_RX_DATA;
                end else begin
                    next_s.rx_baud = s.rx_baud + 1'b1;
                end
            end
            BFSP_RX_DATA: begin
                // mid-bit sampling leaves margin for host rate error
                if (s.rx_baud == BIT_LAST) begin
                    next_s.rx_baud  = '0;
                    next_s.rx_shift = {uart_rx, s.rx_shift[`BFSP_DATA_BITS-1:1]};
                    next_s.rx_bits  = s.rx_bits + 1'b1;
                    if (s.rx_bits == DATA_LAST) begin
                        next_s.rx_st = BFSP_RX_STOP;
                    end
                end else begin
                    next_s.rx_baud = s.rx_baud + 1'b1;
                end
            end
            BFSP_RX_STOP: begin
                if (s.rx_baud == BIT_LAST) begin
                    next_s.rx_baud = '0;
                    next_s.rx_st   = BFSP_RX_IDLE;
                    if (uart_rx) begin
                        next_s.rx_data  = s.rx_shift;
                        next_s.rx_valid = 1'b1;
                    end else begin
                        next_s.rx_err = 1'b1;
                    end
                end else begin
                    next_s.rx_baud = s.rx_baud + 1'b1;
                end
            end
            default: begin
                next_s.rx_st = BFSP_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= S_RST;
        end else begin
            s <= next_s;
        end
    end

    assign uart_tx               = s.tx_line;
    assign module_wake_request_n = s.wake_n;
    assign module_accept_ready_n = s.accept_n;
    assign rx_valid              = s.rx_valid;
    assign rx_data               = s.rx_data;
    assign rx_frame_err          = s.rx_err;
    assign ts_request            = s.ts_req;

endmodule

`default_nettype wire

// ==== verilog/bfsp_regs.svh ====
// timing, field and reset constants of the byte-flow serial port
`ifndef BFSP_REGS_SVH
`define BFSP_REGS_SVH

// clock and line rate
`define BFSP_CLK_KHZ      20000
`define BFSP_BAUD         9600
`define BFSP_BIT_CYC      ((`BFSP_CLK_KHZ * 1000) / `BFSP_BAUD)
`define BFSP_HALF_CYC     (`BFSP_BIT_CYC / 2)

// character framing: start, eight data bits, no parity, one stop
`define BFSP_DATA_BITS    8
`define BFSP_FRAME_BITS   10
`define BFSP_LAST_FLAG    8

// strobe width, rounded up to whole cycles
`define BFSP_STROBE_NS    500
`define BFSP_STROBE_CYC   ((`BFSP_STROBE_NS * `BFSP_CLK_KHZ + 999999) / 1000000)

// acknowledge window and packet spacing
`define BFSP_ACK_MIN_MS   1
`define BFSP_ACK_MAX_MS   500
`define BFSP_ACK_CYC      (`BFSP_ACK_MAX_MS * `BFSP_CLK_KHZ)
`define BFSP_GAP_MS       20
`define BFSP_GAP_CYC      (`BFSP_GAP_MS * `BFSP_CLK_KHZ)

// counter widths and buffer depth
`define BFSP_BAUD_W       12
`define BFSP_BITS_W       4
`define BFSP_LONG_W       24
`define BFSP_FILT_W       4
`define BFSP_FIFO_DEPTH   2

// filtered input positions
`define BFSP_IN_READY     0
`define BFSP_IN_TIME      1
`define BFSP_IN_NUM       2

// line levels at reset
`define BFSP_IDLE_LEVEL   1'b1

`endif

// ==== verilog/bfsp_pkg.sv ====
// types shared by the byte-flow serial port
`include "bfsp_regs.svh"

package bfsp_pkg;

    typedef logic [`BFSP_BAUD_W-1:0] bfsp_baud_t;
    typedef logic [`BFSP_BITS_W-1:0] bfsp_bits_t;
    typedef logic [`BFSP_LONG_W-1:0] bfsp_long_t;
    typedef logic [`BFSP_FILT_W-1:0] bfsp_filt_t;

    typedef enum logic [2:0] {
        BFSP_TX_IDLE = 3'h0,
        BFSP_TX_WAKE = 3'h1,
        BFSP_TX_SEND = 3'h3,
        BFSP_TX_PACE = 3'h2,
        BFSP_TX_GAP  = 3'h6
    } bfsp_tx_state_t;

    typedef enum logic [1:0] {
        BFSP_RX_IDLE  = 2'h0,
        BFSP_RX_START = 2'h1,
        BFSP_RX_DATA  = 2'h3,
        BFSP_RX_STOP  = 2'h2
    } bfsp_rx_state_t;

    typedef struct packed {
        bfsp_tx_state_t                       tx_st;
        bfsp_baud_t                           tx_baud;
        bfsp_bits_t                           tx_bits;
        logic [`BFSP_FRAME_BITS-1:0]          tx_shift;
        logic                                 tx_last;
        logic                                 tx_line;
        logic                                 seen_high;
        bfsp_long_t                           long_cnt;
        logic                                 wake_n;
        logic                                 accept_n;
        bfsp_rx_state_t                       rx_st;
        bfsp_baud_t                           rx_baud;
        bfsp_bits_t                           rx_bits;
        logic [`BFSP_DATA_BITS-1:0]           rx_shift;
        logic                                 rx_prev;
        logic [`BFSP_DATA_BITS-1:0]           rx_data;
        logic                                 rx_valid;
        logic                                 rx_err;
        logic [`BFSP_IN_NUM-1:0]              filt;
        logic [`BFSP_IN_NUM-1:0][`BFSP_FILT_W-1:0] fcnt;
        logic                                 ts_req;
    } bfsp_state_t;

endpackage

// ==== verilog/bfsp_fifo.sv ====
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none

module bfsp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [AW:0]   CNT_FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } bfsp_fifo_state_t;

    bfsp_fifo_state_t s;
    bfsp_fifo_state_t next_s;
    logic             push;
    logic             pop;

    assign in_ready  = (s.cnt != CNT_FULL);
    assign out_valid = (s.cnt != '0);
    assign out_data  = s.mem[s.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = (s.wp == PTR_LAST) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (s.rp == PTR_LAST) ? '0 : s.rp + 1'b1;
        end
        // simultaneous push and pop leave the count alone
        if (push & ~pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (pop & ~push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

`default_nettype wire

// ==== test/bfsp_port_sva.sv ====
// pin-level assertions for the byte-flow serial port
`timescale 1ns/1ns
`default_nettype none
`include "bfsp_regs.svh"

module bfsp_port_sva
    import bfsp_pkg::*;
#(
    parameter int unsigned ACK_CYC = `BFSP_ACK_CYC,
    parameter int unsigned GAP_CYC = `BFSP_GAP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // network status
    input wire logic net_joined,
    input wire logic net_buf_space,
    // serial lines and handshakes
    input wire logic uart_tx,
    input wire logic module_wake_request_n,
    input wire logic host_ready_n,
    input wire logic module_accept_ready_n,
    input wire logic time_strobe_n,
    // core side pulses
    input wire logic rx_valid,
    input wire logic rx_frame_err,
    input wire logic ts_request
);
    // saturating, so the counts never wrap in a long idle stretch
    logic [31:0] wake_cnt;
    logic [31:0] idle_cnt;

    always_ff @(posedge clk) begin
        if (rst || module_wake_request_n) begin
            wake_cnt <= 32'h0;
        end else if (wake_cnt < ACK_CYC + 4) begin
            wake_cnt <= wake_cnt + 32'h1;
        end
        if (rst) begin
            idle_cnt <= GAP_CYC;
        end else if (!uart_tx || !module_wake_request_n) begin
            idle_cnt <= 32'h0;
        end else if (idle_cnt < GAP_CYC) begin
            idle_cnt <= idle_cnt + 32'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence ready_taken;
        (!module_wake_request_n && !host_ready_n) [*8];
    endsequence
    sequence strobe_held;
        $fell(time_strobe_n) ##1 (!time_strobe_n) [*8];
    endsequence

    accept_follow_a: assert property (1'b1 |=> module_accept_ready_n ==
        !($past(net_joined) && $past(net_buf_space))) else $error("accept-ready wrong");
    wake_release_a: assert property (ready_taken |-> ##[1:8] module_wake_request_n)
        else $error("wake not released after ready");
    wake_hold_a: assert property ($rose(module_wake_request_n) |->
        !$past(host_ready_n) || wake_cnt >= ACK_CYC - 2) else $error("wake released early");
    wake_bound_a: assert property (wake_cnt <= ACK_CYC + 2)
        else $error("wake held past timeout");
    gap_kept_a: assert property ($fell(module_wake_request_n) |-> idle_cnt >= GAP_CYC - 2)
        else $error("packet gap too short");
    ready_start_a: assert property ($fell(uart_tx) |->
        !$past(host_ready_n) && !$past(host_ready_n, 9)) else $error("byte without ready");
    start_bit_a: assert property ($fell(uart_tx) |=> (!uart_tx) [*8])
        else $error("start bit too short");
    rx_pulse_a: assert property (rx_valid || rx_frame_err |->
        !(rx_valid && rx_frame_err) ##1 !rx_valid && !rx_frame_err) else $error("rx pulse bad");
    ts_answer_a: assert property (strobe_held |-> ##[0:6] ts_request)
        else $error("strobe not answered");
    ts_clean_a: assert property (ts_request |-> !$past(time_strobe_n, 3) &&
        !$past(time_strobe_n, 8) ##1 !ts_request) else $error("spurious timestamp request");
endmodule

bind bfsp_port bfsp_port_sva #(.ACK_CYC(ACK_CYC), .GAP_CYC(GAP_CYC)) u_sva (
    .clk(clk), .rst(rst), .net_joined(net_joined), .net_buf_space(net_buf_space),
    .uart_tx(uart_tx), .module_wake_request_n(module_wake_request_n),
    .host_ready_n(host_ready_n), .module_accept_ready_n(module_accept_ready_n),
    .time_strobe_n(time_strobe_n), .rx_valid(rx_valid), .rx_frame_err(rx_frame_err),
    .ts_request(ts_request)
);
`default_nettype wire

// ==== test/bfsp_host_model.sv ====
// behavioural host: holds ready low while ack_en is set, pulses it high after each byte when pulse_en is set, captures serial output
`timescale 1ns/1ns
`default_nettype none
`include "bfsp_regs.svh"

module bfsp_host_model
    import bfsp_pkg::*;
(
    // clock, reset and readiness from the bench
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  ack_en,
    input  wire logic  pulse_en,
    // device pins
    input  wire logic  uart_tx,
    input  wire logic  module_wake_request_n,
    output logic       host_ready_n,
    // captured character, stop bit above the data byte
    output logic       got_valid,
    output logic [8:0] got_char
);
    logic [8:0] shift;

    initial begin
        host_ready_n = 1'b1;
        got_valid    = 1'b0;
        got_char     = 9'h000;
        shift        = 9'h000;
        forever begin
            @(posedge clk);
            got_valid    <= 1'b0;
            host_ready_n <= !(ack_en && !rst);
            if (!rst && uart_tx === 1'b0) begin
                repeat (`BFSP_HALF_CYC) @(posedge clk);
                for (int i = 0; i < 9; i++) begin
                    repeat (`BFSP_BIT_CYC) @(posedge clk);
                    shift = {uart_tx, shift[8:1]};
                end
                got_char     <= shift;
                got_valid    <= 1'b1;
                // release well after the start bit and long before the byte deadline
                if (pulse_en) begin
                    host_ready_n <= 1'b1;
                end
                @(posedge clk);
                got_valid <= 1'b0;
                // one microsecond: twice the minimum, past the input filter
                repeat (19) @(posedge clk);
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/byte_flow_serial_port_tb.sv ====
// self-checking bench for the byte-flow serial port
`timescale 1ns/1ns
`default_nettype none
`include "bfsp_regs.svh"

module byte_flow_serial_port_tb
    import bfsp_pkg::*;
;
    localparam int unsigned ACK = 2000;
    localparam int unsigned GAP = 500;
    localparam int          BIT = `BFSP_BIT_CYC;

    logic clk, rst, byte_paced_mode, net_joined, net_buf_space, uart_rx, time_strobe_n;
    logic tx_valid, tx_last, ack_en, uart_tx, wake_n, host_ready_n, accept_n, tx_ready;
    logic rx_valid, rx_frame_err, ts_request, got_valid, pulse_en;
    logic [7:0] tx_data, rx_data, b, rb, last_good;
    logic [8:0] got_char;
    logic [8:0] tx_q[$];
    logic [9:0] rx_q[$];
    int failures, total_checks, seed, n, ts_cnt, per;

    bfsp_port #(.ACK_CYC(ACK), .GAP_CYC(GAP)) uut (
        .clk(clk), .rst(rst), .byte_paced_mode(byte_paced_mode), .net_joined(net_joined),
        .net_buf_space(net_buf_space), .uart_tx(uart_tx), .uart_rx(uart_rx),
        .module_wake_request_n(wake_n), .host_ready_n(host_ready_n),
        .module_accept_ready_n(accept_n), .time_strobe_n(time_strobe_n),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_err(rx_frame_err),
        .ts_request(ts_request));

    bfsp_host_model u_host (
        .clk(clk), .rst(rst), .ack_en(ack_en), .pulse_en(pulse_en), .uart_tx(uart_tx),
        .module_wake_request_n(wake_n), .host_ready_n(host_ready_n),
        .got_valid(got_valid), .got_char(got_char));

    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        total_checks++;
        if (seen !== expected) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // leaves tx_valid high so back-to-back pushes never re-drive it in one step
    task automatic push(input logic [7:0] d, input logic l);
        tx_q.push_back({1'b1, d});
        tx_valid <= 1'b1;
        tx_data  <= d;
        tx_last  <= l;
        n = 0;
        @(posedge clk);
        while (tx_ready !== 1'b1 && n < 50000) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic wait_wake(input logic lvl, input int lim);
        n = 0;
        while (wake_n !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic send_rx(input logic [7:0] d, input logic stp, input int cyc);
        logic [9:0] fr;
        fr = {stp, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            uart_rx <= fr[i];
            repeat (cyc) @(posedge clk);
        end
        uart_rx <= 1'b1;
        repeat (cyc) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        if (ts_request === 1'b1) ts_cnt++;
        if (got_valid === 1'b1 && tx_q.size() > 0) check(16'(got_char), 16'(tx_q.pop_front()));
        else if (got_valid === 1'b1) check(16'h1, 16'h0);
        if ((rx_valid === 1'b1 || rx_frame_err === 1'b1) && rx_q.size() > 0)
            check(16'({rx_frame_err, rx_valid, rx_data}), 16'(rx_q.pop_front()));
        else if (rx_valid === 1'b1 || rx_frame_err === 1'b1) check(16'h2, 16'h0);
    end

    initial begin
        repeat (98000) @(posedge clk);
        failures++;
        finish_test();
    end

    initial begin
        {failures, total_checks, ts_cnt, n, per} = '0;
        seed = 45;
        {rst, uart_rx, time_strobe_n} = 3'h7;
        {byte_paced_mode, net_joined, net_buf_space, tx_valid, tx_last, ack_en, pulse_en} = 7'h00;
        {tx_data, b, rb, last_good} = '0;
        repeat (12) @(posedge clk);
        check(16'({uart_tx, wake_n, accept_n, rx_valid, rx_frame_err, ts_request, tx_ready, rx_data}),
              16'h7100);
        rst <= 1'b0;
        fork
            begin
                // host asleep: wake times out, retries after the gap, then is answered
                b = 8'($random(seed));
                push(b, 1'b0);
                push(8'($random(seed)), 1'b1);
                tx_valid <= 1'b0;
                wait_wake(1'b0, 100);
                wait_wake(1'b1, ACK + 100);
                check(16'(n >= ACK - 4 && n <= ACK + 4), 16'h1);
                wait_wake(1'b0, GAP + 100);
                check(16'(n >= GAP - 4 && n <= GAP + 20), 16'h1);
                ack_en <= 1'b1;
                wait_wake(1'b1, 100);
                check(16'(n <= 15), 16'h1);
                wait (tx_q.size() == 0);
                // byte pacing: fill both entries while the host is not ready
                ack_en <= 1'b0;
                byte_paced_mode <= 1'b1;
                repeat (50) @(posedge clk);
                push(8'($random(seed)), 1'b0);
                push(8'($random(seed)), 1'b1);
                tx_valid <= 1'b0;
                repeat (BIT + GAP) @(posedge clk);
                check(16'({wake_n, tx_ready}), 16'h0);
                ack_en <= 1'b1;
                wait (tx_q.size() == 1);
                // ready held low: no next start before a ready pulse
                repeat (BIT) @(posedge clk);
                check(16'(tx_q.size()), 16'h1);
                pulse_en <= 1'b1;
                ack_en   <= 1'b0;
                repeat (25) @(posedge clk);
                ack_en <= 1'b1;
                n = 0;
                while (tx_q.size() != 0 && n < 30 * BIT) begin
                    @(posedge clk);
                    n++;
                end
            end
            begin
                repeat (100) @(posedge clk);
                // rate error at both tolerance limits, and a low stop bit in between
                for (int k = 0; k < 3; k++) begin
                    rb = 8'($random(seed));
                    per = (k == 0) ? BIT * 98 / 100 : (k == 2) ? BIT * 102 / 100 : BIT;
                    if (k == 1) rx_q.push_back({2'b10, last_good});
                    else rx_q.push_back({2'b01, rb});
                    if (k != 1) last_good = rb;
                    if (k == 2) check(16'(accept_n), 16'h0);
                    send_rx(rb, k != 1, per);
                end
            end
            begin
                for (int k = 0; k < 8; k++) begin
                    {net_joined, net_buf_space} <= 2'($random(seed));
                    repeat (2) @(posedge clk);
                    check(16'(accept_n), 16'(!(net_joined && net_buf_space)));
                end
                // not a member while host packets arrive
                net_joined <= 1'b0;
                time_strobe_n <= 1'b0;
                repeat (5) @(posedge clk);
                time_strobe_n <= 1'b1;
                repeat (30) @(posedge clk);
                check(16'(ts_cnt), 16'h0);
                time_strobe_n <= 1'b0;
                repeat (12) @(posedge clk);
                time_strobe_n <= 1'b1;
                repeat (30) @(posedge clk);
                check(16'(ts_cnt), 16'h1);
                repeat (BIT * 12) @(posedge clk);
                {net_joined, net_buf_space} <= 2'b11;
            end
        join
        repeat (BIT) @(posedge clk);
        check(16'(tx_q.size() + rx_q.size()), 16'h0);
        finish_test();
    end
endmodule
`default_nettype wire
